// ===== rtl/gpib_srq_pkg.sv
// Constants for the service request and status byte block
package gpib_srq_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_SRQ_COND = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_MODE = 8'h0c;
  localparam logic [7:0] OFF_STATE = 8'h10;
  // ----------------------------------------------------------------
  // Status byte fields
  // ----------------------------------------------------------------
  localparam int SB_DATA_READY = 0;
  localparam int SB_CODE_ERR = 1;
  localparam int SB_INST_ERR = 2;
  localparam int SB_RQS = 6;
  localparam logic [7:0] SB_RESET = 8'h00;
  localparam logic [7:0] EN_MASK = 8'h05;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam int MODE_TALK_ONLY = 0;
  localparam logic [4:0] ADDR_RESET = 5'h1c;
  // ----------------------------------------------------------------
  // Bus commands, seven bits, taken while attention is true
  // ----------------------------------------------------------------
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_PPC = 7'h05;
  localparam logic [6:0] CMD_TCT = 7'h09;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_PPU = 7'h15;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [6:0] CMD_UNT = 7'h5f;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  // ----------------------------------------------------------------
  // Measurement error and bus responses
  // ----------------------------------------------------------------
  localparam logic [7:0] MEAS_TRIES = 8'h80;
  localparam logic [7:0] ERR_MEAS = 8'h1f;
  localparam logic [7:0] ERR_BUS_CODE = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== rtl/gpib_service_request_status.sv
// Service request, status byte and addressing logic of the instrument
// Contract
// - Remote enable false returns to local, settings kept, remote lamp off.
// - Pass control is ignored; never becomes controller.
// - Service request via SRQ, possible in local or remote.
// - Pending request withdrawn by serial poll or device clear.
// - SRQ released just before status byte goes on the data lines; the code drops it in the same cycle dio_oe_o rises.
// - Program-code error always raises service request.
// - Data ready flagged when non-error, non-status output is pending.
// - Invalid data message flags a program-code error.
// - After set attempts without result, error 31 shown and request raised.
// - Instrument error flagged whenever any error is displayed.
// - Condition enables set by panel or bus; all disabled on clear.
// - Eight-bit status byte, three bits for enabled conditions.
// - Enabled condition sets its bit, request bit and SRQ.
// - Disabled condition sets no bit and no request; measurement error still sets instrument error bit and request.
// - Status byte frozen while serial poll mode lasts.
// - Serial poll enable then talk address; device sends status byte.
// - After sending, byte cleared on poll disable, interface clear, untalk.
// - Device clear clears status byte and pending request always.
// - Talk-only clears status byte on each byte sent; outside poll mode the code reloads it with the live conditions instead.
// - No parallel poll response, no parallel poll bit driven.
// - Interface clear unaddresses and stops talking or listening at once.
// - Bus address from internal setting, default twenty-eight.
// - Bits 1,2,3,7 as defined; bits 4,5,6,8 read zero.
// - Set status bits stay set until the whole byte is cleared.
// - Selected clear while listening equals universal clear.
module gpib_service_request_status (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register bus
  input wire logic axi_awvalid_i,
  output logic axi_awready_o,
  input wire logic [7:0] axi_awaddr_i,
  input wire logic axi_wvalid_i,
  output logic axi_wready_o,
  input wire logic [31:0] axi_wdata_i,
  input wire logic [3:0] axi_wstrb_i,
  output logic axi_bvalid_o,
  input wire logic axi_bready_i,
  output logic [1:0] axi_bresp_o,
  input wire logic axi_arvalid_i,
  output logic axi_arready_o,
  input wire logic [7:0] axi_araddr_i,
  output logic axi_rvalid_o,
  input wire logic axi_rready_i,
  output logic [31:0] axi_rdata_o,
  output logic [1:0] axi_rresp_o,
  // Bus lines and decoded messages
  input wire logic ren_i,
  input wire logic ifc_i,
  input wire logic cmd_valid_i,
  input wire logic [6:0] cmd_i,
  input wire logic data_msg_i,
  input wire logic data_invalid_i,
  input wire logic byte_taken_i,
  // Instrument side
  input wire logic out_pending_i,
  input wire logic out_is_error_i,
  input wire logic inst_error_i,
  input wire logic meas_try_i,
  input wire logic meas_result_i,
  input wire logic fp_cond_we_i,
  input wire logic [7:0] fp_cond_i,
  // Bus outputs
  output logic srq_o,
  output logic [7:0] dio_o,
  output logic dio_oe_o,
  // Indicators
  output logic remote_o,
  output logic talk_o,
  output logic listen_o,
  output logic clear_o,
  output logic [7:0] err_code_o
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_cmd(input logic [6:0] c);
    return cmd_valid_i && (cmd_i == c);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a == gpib_srq_pkg::OFF_SRQ_COND || a == gpib_srq_pkg::OFF_STATUS ||
           a == gpib_srq_pkg::OFF_ADDR || a == gpib_srq_pkg::OFF_MODE ||
           a == gpib_srq_pkg::OFF_STATE;
  endfunction

  logic [7:0] sb_q;
  logic [7:0] en_q;
  logic [4:0] addr_q;
  logic talk_only_q;
  logic remote_q;
  logic talk_q;
  logic listen_q;
  logic spe_q;
  logic sent_q;
  logic code_disp_q;
  logic meas_err_q;
  logic [7:0] meas_cnt_q;
  logic [7:0] dio_q;
  logic clear_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic my_listen;
  logic my_talk;
  logic other_talk;
  logic clear_evt;
  logic disp_err;
  logic [7:0] cond;
  logic [7:0] set_bits;
  logic sb_clr;
  logic poll_out;
  logic aw_fire;
  logic ar_fire;

  assign my_listen = cmd_valid_i && cmd_i[6:5] == gpib_srq_pkg::GRP_LISTEN
                     && cmd_i[4:0] == addr_q;
  assign my_talk = cmd_valid_i && cmd_i[6:5] == gpib_srq_pkg::GRP_TALK
                   && cmd_i[4:0] == addr_q;
  // Reads inside a function would not wake a continuous assign
  always_comb begin
    other_talk = (cmd_valid_i && cmd_i[6:5] == gpib_srq_pkg::GRP_TALK
                  && cmd_i[4:0] != addr_q) || is_cmd(gpib_srq_pkg::CMD_UNT);
    // Both clear forms act the same
    clear_evt = is_cmd(gpib_srq_pkg::CMD_DCL)
                || (is_cmd(gpib_srq_pkg::CMD_SDC) && listen_q);
  end
  // Pass control and parallel poll commands fall through undecoded
  // so no state ever moves on them.

  // ----------------------------------------------------------------
  // Addressing and remote state
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      remote_q <= 1'b0;
    end else if (!ren_i) begin
      remote_q <= 1'b0;
    end else if (my_listen) begin
      remote_q <= 1'b1;
    end else if (is_cmd(gpib_srq_pkg::CMD_GTL) && listen_q) begin
      remote_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      listen_q <= 1'b0;
      talk_q <= 1'b0;
    end else if (ifc_i) begin
      listen_q <= 1'b0;
      talk_q <= 1'b0;
    end else begin
      if (my_listen) begin
        listen_q <= 1'b1;
      end else if (is_cmd(gpib_srq_pkg::CMD_UNL)) begin
        listen_q <= 1'b0;
      end
      if (my_talk) begin
        talk_q <= 1'b1;
      end else if (other_talk) begin
        talk_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      spe_q <= 1'b0;
    end else if (ifc_i || is_cmd(gpib_srq_pkg::CMD_SPD)) begin
      spe_q <= 1'b0;
    end else if (is_cmd(gpib_srq_pkg::CMD_SPE)) begin
      spe_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Error conditions
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || clear_evt) begin
      code_disp_q <= 1'b0;
    end else if (data_msg_i) begin
      code_disp_q <= data_invalid_i;
    end
  end

  // Attempts are counted only while no result arrives
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || meas_result_i || clear_evt) begin
      meas_cnt_q <= 8'h00;
      meas_err_q <= 1'b0;
    end else if (meas_try_i && !meas_err_q) begin
      meas_cnt_q <= meas_cnt_q + 8'h01;
      meas_err_q <= (meas_cnt_q + 8'h01) == gpib_srq_pkg::MEAS_TRIES;
    end
  end

  assign disp_err = inst_error_i || code_disp_q || meas_err_q;

  always_comb begin
    cond = 8'h00;
    cond[gpib_srq_pkg::SB_DATA_READY] = out_pending_i && !out_is_error_i;
    cond[gpib_srq_pkg::SB_CODE_ERR] = code_disp_q;
    cond[gpib_srq_pkg::SB_INST_ERR] = disp_err;
    // Code error is always enabled, the other two by the setting
    set_bits = cond & (en_q | 8'h02);
    if (meas_err_q) begin
      set_bits[gpib_srq_pkg::SB_INST_ERR] = 1'b1;
    end
    if (set_bits != 8'h00) begin
      set_bits[gpib_srq_pkg::SB_RQS] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Status byte
  // ----------------------------------------------------------------
  always_comb begin
    sb_clr = (sent_q && (ifc_i || is_cmd(gpib_srq_pkg::CMD_SPD) || other_talk))
             || (talk_only_q && byte_taken_i);
  end
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sent_q <= 1'b0;
    end else if (sb_clr || clear_evt) begin
      sent_q <= 1'b0;
    end else if (byte_taken_i && spe_q && talk_q) begin
      sent_q <= 1'b1;
    end
  end

  // A clear message wins over level conditions so it sticks;
  // a poll clear zeroes the byte; only the talk-only clear reloads live conditions.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || clear_evt) begin
      sb_q <= gpib_srq_pkg::SB_RESET;
    end else if (sb_clr) begin
      sb_q <= spe_q ? gpib_srq_pkg::SB_RESET : set_bits;
    end else if (!spe_q) begin
      sb_q <= sb_q | set_bits;
    end
    // No update while in poll mode
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      dio_q <= 8'h00;
      clear_q <= 1'b0;
    end else begin
      dio_q <= sb_q;
      clear_q <= clear_evt;
    end
  end

  // Request bit drives SRQ; released while the poll byte is out
  assign poll_out = spe_q && talk_q;
  assign srq_o = sb_q[gpib_srq_pkg::SB_RQS] && !poll_out;
  assign dio_oe_o = (poll_out || talk_only_q) && !ifc_i;
  assign dio_o = dio_q;
  assign remote_o = remote_q;
  assign talk_o = talk_q;
  assign listen_o = listen_q;
  assign clear_o = clear_q;
  assign err_code_o = meas_err_q ? gpib_srq_pkg::ERR_MEAS :
                      (code_disp_q ? gpib_srq_pkg::ERR_BUS_CODE : 8'h00);

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  // Address and data are only taken together; simpler than buffering
  assign aw_fire = axi_awvalid_i && axi_wvalid_i && !bvalid_q;
  assign axi_awready_o = aw_fire;
  assign axi_wready_o = aw_fire;
  assign ar_fire = axi_arvalid_i && !rvalid_q;
  assign axi_arready_o = !rvalid_q;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || clear_evt) begin
      en_q <= gpib_srq_pkg::EN_RESET;
    end else if (fp_cond_we_i) begin
      en_q <= fp_cond_i & gpib_srq_pkg::EN_MASK;
    end else if (aw_fire && axi_wstrb_i[0]
                 && axi_awaddr_i == gpib_srq_pkg::OFF_SRQ_COND) begin
      en_q <= axi_wdata_i[7:0] & gpib_srq_pkg::EN_MASK;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      addr_q <= gpib_srq_pkg::ADDR_RESET;
      talk_only_q <= 1'b0;
    end else if (aw_fire && axi_wstrb_i[0]) begin
      if (axi_awaddr_i == gpib_srq_pkg::OFF_ADDR) begin
        addr_q <= axi_wdata_i[4:0];
      end
      if (axi_awaddr_i == gpib_srq_pkg::OFF_MODE) begin
        talk_only_q <= axi_wdata_i[gpib_srq_pkg::MODE_TALK_ONLY];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= gpib_srq_pkg::RESP_OKAY;
    end else if (aw_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= is_mapped(axi_awaddr_i) ? gpib_srq_pkg::RESP_OKAY
                                         : gpib_srq_pkg::RESP_SLVERR;
    end else if (axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= gpib_srq_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= is_mapped(axi_araddr_i) ? gpib_srq_pkg::RESP_OKAY
                                         : gpib_srq_pkg::RESP_SLVERR;
      unique case (axi_araddr_i)
        gpib_srq_pkg::OFF_SRQ_COND: rdata_q <= {24'h00_0000, en_q};
        gpib_srq_pkg::OFF_STATUS: rdata_q <= {24'h00_0000, sb_q};
        gpib_srq_pkg::OFF_ADDR: rdata_q <= {27'h000_0000, addr_q};
        gpib_srq_pkg::OFF_MODE: rdata_q <= {31'h0000_0000, talk_only_q};
        gpib_srq_pkg::OFF_STATE: rdata_q <= {24'h00_0000, meas_err_q, code_disp_q,
                                             sent_q, spe_q, listen_q, talk_q,
                                             remote_q, srq_o};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else if (axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  assign axi_bvalid_o = bvalid_q;
  assign axi_bresp_o = bresp_q;
  assign axi_rvalid_o = rvalid_q;
  assign axi_rdata_o = rdata_q;
  assign axi_rresp_o = rresp_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_bad_data;
    data_msg_i && data_invalid_i && !spe_q && !cmd_valid_i;
  endsequence
  sequence s_quiet;
    !cmd_valid_i && !data_msg_i && !meas_result_i;
  endsequence
  property p_ren_local;
    !ren_i |=> !remote_o;
  endproperty
  a_ren_local: assert property (p_ren_local) else $error("remote kept");
  property p_tct_ignored;
    cmd_valid_i && cmd_i == gpib_srq_pkg::CMD_TCT && !ifc_i
      |=> $stable(talk_o) && $stable(listen_o);
  endproperty
  a_tct_ignored: assert property (p_tct_ignored) else $error("tct acted");
  property p_code_err;
    s_bad_data ##1 (s_quiet and !spe_q) |=> sb_q[1] && sb_q[6] && srq_o;
  endproperty
  a_code_err: assert property (p_code_err) else $error("no code srq");
  property p_dcl;
    cmd_valid_i && cmd_i == gpib_srq_pkg::CMD_DCL
      |=> sb_q == 8'h00 && en_q == 8'h00 && !srq_o;
  endproperty
  a_dcl: assert property (p_dcl) else $error("clear missed");
  property p_freeze;
    spe_q && !sb_clr && !clear_evt |=> $stable(sb_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("byte moved");
  property p_release;
    spe_q && talk_q |-> !srq_o && (dio_oe_o || ifc_i);
  endproperty
  a_release: assert property (p_release) else $error("srq held");
  property p_ifc;
    ifc_i && !talk_only_q |=> !talk_o && !listen_o && !dio_oe_o;
  endproperty
  a_ifc: assert property (p_ifc) else $error("ifc ignored");
  property p_disabled;
    !en_q[0] && !sb_q[0] && !fp_cond_we_i |=> !sb_q[0];
  endproperty
  a_disabled: assert property (p_disabled) else $error("bit set");
  property p_sticky;
    sb_q[2] && !sb_clr && !clear_evt |=> sb_q[2];
  endproperty
  a_sticky: assert property (p_sticky) else $error("bit lost");
  property p_zero;
    sb_q[7] == 1'b0 && sb_q[5:3] == 3'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("reserved set");
  property p_meas;
    (meas_try_i && meas_cnt_q == 8'h7f && !meas_err_q && !spe_q) and s_quiet
      |=> ##1 sb_q[6] || spe_q;
  endproperty
  a_meas: assert property (p_meas) else $error("no meas srq");
endmodule

// ===== testbench/gpib_ctrl_model.sv
// Bus controller model: commands, data messages, polls and handshake
module gpib_ctrl_model (
  // Clock
  input wire logic clock_i,
  // From the device
  input wire logic dio_oe_i,
  // Controller lines
  output logic ren_o,
  output logic ifc_o,
  output logic cmd_valid_o,
  output logic [6:0] cmd_o,
  output logic data_msg_o,
  output logic data_invalid_o,
  output logic byte_taken_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {ren_o, ifc_o, cmd_valid_o, data_msg_o, data_invalid_o, byte_taken_o} = 6'h00;
    cmd_o = 7'h00;
  end
  // ---------------------------------------------------------------
  // Transfers
  // ---------------------------------------------------------------
  // Released command lines show the inverse, never a stale copy
  task automatic pulse_cmd(input logic [6:0] c);
    @(posedge clock_i);
    cmd_valid_o <= 1'b1;
    cmd_o <= c;
    @(posedge clock_i);
    cmd_valid_o <= 1'b0;
    cmd_o <= ~c;
  endtask
  task automatic data_byte(input logic bad);
    @(posedge clock_i);
    data_msg_o <= 1'b1;
    data_invalid_o <= bad;
    @(posedge clock_i);
    data_msg_o <= 1'b0;
    data_invalid_o <= ~bad;
  endtask
  task automatic abort();
    @(posedge clock_i);
    ifc_o <= 1'b1;
    @(posedge clock_i);
    ifc_o <= 1'b0;
  endtask
  task automatic set_ren(input logic v);
    @(posedge clock_i);
    ren_o <= v;
  endtask
  // Slow acceptance stretches the frozen window
  task automatic take_byte(input int wait_n, output logic ok);
    ok = 1'b0;
    repeat (wait_n) @(posedge clock_i);
    for (int i = 0; i < 50 && !ok; i++) begin
      @(posedge clock_i);
      ok = dio_oe_i;
    end
    if (ok) begin
      byte_taken_o <= 1'b1;
      @(posedge clock_i);
      byte_taken_o <= 1'b0;
    end
  endtask
  task automatic poll(input logic [4:0] a);
    pulse_cmd(gpib_srq_pkg::CMD_SPE);
    pulse_cmd({gpib_srq_pkg::GRP_TALK, a});
  endtask
endmodule

// ===== testbench/gpib_service_request_status_tb.sv
// Self-checking bench for the service request and status byte block
module gpib_service_request_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i;
  logic rst_n_i;
  logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  logic [7:0] aw_a, ar_a, fpc, dio, err;
  logic [31:0] w_d, r_d;
  logic [1:0] b_resp, r_resp;
  logic ren, ifc, cv, dm, di, bt, pend, iserr, ierr, mtry, mres, fpwe;
  logic srq, dio_oe, remote, talk, listen, clr;
  logic [6:0] cmd_w;
  logic [3:0] strb;
  logic [6:0] ign [3] = '{gpib_srq_pkg::CMD_TCT, gpib_srq_pkg::CMD_PPC, gpib_srq_pkg::CMD_PPU};
  int mismatches = 0;
  int tests_run = 0;
  gpib_service_request_status u_gpib_service_request_status (
    .clock_i(clock_i), .rst_n_i(rst_n_i),
    .axi_awvalid_i(aw_v), .axi_awready_o(aw_r), .axi_awaddr_i(aw_a),
    .axi_wvalid_i(w_v), .axi_wready_o(w_r), .axi_wdata_i(w_d), .axi_wstrb_i(strb),
    .axi_bvalid_o(b_v), .axi_bready_i(b_r), .axi_bresp_o(b_resp),
    .axi_arvalid_i(ar_v), .axi_arready_o(ar_r), .axi_araddr_i(ar_a),
    .axi_rvalid_o(r_v), .axi_rready_i(r_r), .axi_rdata_o(r_d), .axi_rresp_o(r_resp),
    .ren_i(ren), .ifc_i(ifc), .cmd_valid_i(cv), .cmd_i(cmd_w), .data_msg_i(dm),
    .data_invalid_i(di), .byte_taken_i(bt), .out_pending_i(pend), .out_is_error_i(iserr),
    .inst_error_i(ierr), .meas_try_i(mtry), .meas_result_i(mres), .fp_cond_we_i(fpwe),
    .fp_cond_i(fpc), .srq_o(srq), .dio_o(dio), .dio_oe_o(dio_oe), .remote_o(remote),
    .talk_o(talk), .listen_o(listen), .clear_o(clr), .err_code_o(err));
  gpib_ctrl_model u_gpib_ctrl_model (
    .clock_i(clock_i), .dio_oe_i(dio_oe), .ren_o(ren), .ifc_o(ifc), .cmd_valid_o(cv),
    .cmd_o(cmd_w), .data_msg_o(dm), .data_invalid_o(di), .byte_taken_o(bt));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bound(input int i);
    if (i >= 64) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock_i);
    aw_v <= 1'b1;
    aw_a <= a;
    w_v <= 1'b1;
    w_d <= d;
    b_r <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge clock_i);
      if (aw_r && w_r) break;
    end
    bound(i);
    aw_v <= 1'b0;
    w_v <= 1'b0;
    for (i = 0; i < 64; i++) begin
      @(posedge clock_i);
      if (b_v) break;
    end
    bound(i);
    b_r <= 1'b0;
    check("bresp", 32'h0000_0000, 32'(b_resp));
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    int i;
    @(posedge clock_i);
    ar_v <= 1'b1;
    ar_a <= a;
    r_r <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge clock_i);
      if (ar_r) break;
    end
    bound(i);
    ar_v <= 1'b0;
    for (i = 0; i < 64; i++) begin
      @(posedge clock_i);
      if (r_v) break;
    end
    bound(i);
    r_r <= 1'b0;
    check(n, e, r_d);
    check({n, " resp"}, 32'(a > gpib_srq_pkg::OFF_STATE ? 2'h2 : 2'h0), 32'(r_resp));
  endtask
  task automatic cmd(input logic [6:0] c);
    u_gpib_ctrl_model.pulse_cmd(c);
  endtask
  function automatic logic [7:0] exp_sb(input logic [7:0] en, input logic dr, input logic ie);
    logic [7:0] s;
    s = {5'h00, ie & en[2], 1'b0, dr & en[0]};
    s[gpib_srq_pkg::SB_RQS] = |s;
    return s;
  endfunction
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  initial begin
    repeat (100000) @(posedge clock_i);
    mismatches++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [15:0] lf;
    logic [7:0] en;
    logic ok;
    {aw_v, w_v, b_r, ar_v, r_r, pend, iserr, ierr, mtry, mres, fpwe} = 11'h000;
    aw_a = 8'h00;
    ar_a = 8'h00;
    w_d = 32'h0000_0000;
    fpc = 8'h00;
    strb = 4'hf;
    rst_n_i = 1'b0;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd_chk("addr", gpib_srq_pkg::OFF_ADDR, 32'h0000_001c);
    rd_chk("status", gpib_srq_pkg::OFF_STATUS, 32'h0000_0000);
    rd_chk("unmapped", 8'h14, 32'h0000_0000);
    // Low byte lane off: the write must not land
    strb <= 4'he;
    axi_wr(gpib_srq_pkg::OFF_ADDR, 32'h0000_0007);
    strb <= 4'hf;
    rd_chk("strb off", gpib_srq_pkg::OFF_ADDR, 32'h0000_001c);
    axi_wr(gpib_srq_pkg::OFF_ADDR, 32'h0000_0007);
    cmd({gpib_srq_pkg::GRP_TALK, 5'h07});
    settle(1);
    check("talk addr", 32'h0000_0001, 32'(talk));
    cmd(gpib_srq_pkg::CMD_UNT);
    axi_wr(gpib_srq_pkg::OFF_ADDR, 32'h0000_001c);
    u_gpib_ctrl_model.data_byte(1'b1);
    settle(3);
    check("err code", 32'(gpib_srq_pkg::ERR_BUS_CODE), 32'(err));
    check("srq local", 32'h0000_0001, 32'({remote, srq}));
    u_gpib_ctrl_model.data_byte(1'b0);
    settle(3);
    rd_chk("sticky", gpib_srq_pkg::OFF_STATUS, 32'h0000_0042);
    // Refused commands leave addressing and status alone
    for (int k = 0; k < 3; k++) begin
      cmd(ign[k]);
      settle(2);
      check("ignored", 32'h0000_0001, 32'({talk, listen, dio_oe, srq}));
    end
    cmd(gpib_srq_pkg::CMD_SDC);
    rd_chk("sdc unlistened", gpib_srq_pkg::OFF_STATUS, 32'h0000_0042);
    u_gpib_ctrl_model.set_ren(1'b1);
    cmd({gpib_srq_pkg::GRP_LISTEN, 5'h1c});
    settle(1);
    check("remote", 32'h0000_0003, 32'({remote, listen}));
    cmd(gpib_srq_pkg::CMD_SDC);
    rd_chk("sdc", gpib_srq_pkg::OFF_STATUS, 32'h0000_0000);
    check("srq sdc", 32'h0000_0000, 32'(srq));
    u_gpib_ctrl_model.set_ren(1'b0);
    settle(2);
    check("local", 32'h0000_0000, 32'(remote));
    cmd(gpib_srq_pkg::CMD_UNL);
    // Poll, freeze, then each clearing cause after the byte went out
    for (int k = 0; k < 3; k++) begin
      axi_wr(gpib_srq_pkg::OFF_SRQ_COND, 32'h0000_0001);
      u_gpib_ctrl_model.data_byte(1'b1);
      u_gpib_ctrl_model.data_byte(1'b0);
      u_gpib_ctrl_model.poll(5'h1c);
      settle(1);
      check("poll", 32'h0000_0542, 32'({talk, srq, dio_oe, dio}));
      @(posedge clock_i);
      pend <= 1'b1;
      rd_chk("frozen", gpib_srq_pkg::OFF_STATUS, 32'h0000_0042);
      @(posedge clock_i);
      pend <= 1'b0;
      u_gpib_ctrl_model.take_byte(k * 3, ok);
      check("byte taken", 32'h0000_0001, 32'(ok));
      if (k == 0) cmd(gpib_srq_pkg::CMD_SPD);
      else if (k == 1) u_gpib_ctrl_model.abort();
      else cmd(gpib_srq_pkg::CMD_UNT);
      settle(2);
      if (k > 0) check("unaddressed", 32'h0000_0000, 32'({talk, listen}));
      rd_chk("poll clear", gpib_srq_pkg::OFF_STATUS, 32'h0000_0000);
      cmd(gpib_srq_pkg::CMD_UNT);
    end
    // Untalk alone leaves poll mode on; end it as a controller would
    cmd(gpib_srq_pkg::CMD_SPD);
    axi_wr(gpib_srq_pkg::OFF_MODE, 32'h0000_0001);
    u_gpib_ctrl_model.data_byte(1'b1);
    u_gpib_ctrl_model.data_byte(1'b0);
    settle(3);
    check("talk only", 32'h0000_0142, 32'({dio_oe, dio}));
    u_gpib_ctrl_model.take_byte(1, ok);
    rd_chk("talk only clr", gpib_srq_pkg::OFF_STATUS, 32'h0000_0000);
    axi_wr(gpib_srq_pkg::OFF_MODE, 32'h0000_0000);
    // A result restarts the attempt count
    @(posedge clock_i);
    mtry <= 1'b1;
    repeat (100) @(posedge clock_i);
    mtry <= 1'b0;
    mres <= 1'b1;
    @(posedge clock_i);
    mres <= 1'b0;
    mtry <= 1'b1;
    repeat (127) @(posedge clock_i);
    mtry <= 1'b0;
    settle(2);
    check("meas 127", 32'h0000_0000, 32'(err));
    @(posedge clock_i);
    mtry <= 1'b1;
    @(posedge clock_i);
    mtry <= 1'b0;
    settle(3);
    check("meas 128", 32'(gpib_srq_pkg::ERR_MEAS), 32'(err));
    rd_chk("meas status", gpib_srq_pkg::OFF_STATUS, 32'h0000_0044);
    cmd(gpib_srq_pkg::CMD_DCL);
    lf = 16'h3295;
    for (int k = 0; k < 8; k++) begin
      lf = lfsr(lf);
      en = lf[7:0] & gpib_srq_pkg::EN_MASK;
      if (lf[5]) begin
        @(posedge clock_i);
        fpwe <= 1'b1;
        fpc <= lf[7:0];
        @(posedge clock_i);
        fpwe <= 1'b0;
      end else begin
        axi_wr(gpib_srq_pkg::OFF_SRQ_COND, 32'(lf[7:0]));
      end
      rd_chk("enables", gpib_srq_pkg::OFF_SRQ_COND, 32'(en));
      @(posedge clock_i);
      pend <= lf[8];
      iserr <= lf[9];
      ierr <= lf[10];
      rd_chk("status", gpib_srq_pkg::OFF_STATUS, 32'(exp_sb(en, lf[8] & ~lf[9], lf[10])));
      check("srq", 32'(|exp_sb(en, lf[8] & ~lf[9], lf[10])), 32'(srq));
      @(posedge clock_i);
      {pend, iserr, ierr} <= 3'h0;
      cmd(gpib_srq_pkg::CMD_DCL);
      #1;
      check("clear pulse", 32'h0000_0001, 32'(clr));
      rd_chk("dcl en", gpib_srq_pkg::OFF_SRQ_COND, 32'h0000_0000);
      rd_chk("dcl status", gpib_srq_pkg::OFF_STATUS, 32'h0000_0000);
    end
    wrap_up();
  end
endmodule
